// [hw/compare_skip_map.svh]
// named opcodes, field positions and constants of the compare and skip unit
`ifndef COMPARE_SKIP_MAP_SVH
`define COMPARE_SKIP_MAP_SVH

// instruction word field positions
`define CSU_OP7_HI 15
`define CSU_OP7_LO 9
`define CSU_OP6_LO 10
`define CSU_DEST_BIT 9
`define CSU_BANK_BIT 8
`define CSU_FILE_HI 7
`define CSU_FILE_LO 0

// opcode prefixes, upper seven or six bits
`define CSU_OP_SKIP_LESS 7'h30
`define CSU_OP_SKIP_EQUAL 7'h31
`define CSU_OP_SKIP_GREATER 7'h32
`define CSU_OP_COMPLEMENT 6'h07

// access bank split and page numbers
`define CSU_INDEX_LIMIT 8'h5f
`define CSU_ACCESS_LOW_PAGE 4'h0
`define CSU_ACCESS_HIGH_PAGE 4'hf

// no-operation cycle counts after a taken skip
`define CSU_NOP_ONE_WORD 2'h1
`define CSU_NOP_TWO_WORD 2'h2
`define CSU_NOP_NONE 2'h0
`define CSU_NOP_STEP 2'h1

// reset values
`define CSU_BYTE_ZERO 8'h00
`define CSU_ADDR_ZERO 12'h000

`endif

// [hw/compare_skip_pkg.sv]
// types shared by the compare and skip unit
package compare_skip_pkg;

	// quarter phases of one instruction cycle, gray coded in order
	typedef enum logic [1:0] {
		PH_DECODE = 2'b00,
		PH_READ = 2'b01,
		PH_PROCESS = 2'b11,
		PH_WRITE = 2'b10
	} phase_t;

	typedef enum logic [2:0] {
		OP_NONE = 3'h0,
		OP_SKIP_EQUAL = 3'h1,
		OP_SKIP_GREATER = 3'h2,
		OP_SKIP_LESS = 3'h3,
		OP_COMPLEMENT = 3'h4
	} op_t;

	typedef struct packed {
		phase_t phase;
		op_t op;
		logic dest_working;
		logic [7:0] operand;
		logic [7:0] working;
		logic [7:0] result;
		logic [1:0] nop_left;
		logic nop_cycle;
		logic flush;
		logic [11:0] mem_addr;
		logic mem_rd;
		logic mem_wr;
		logic working_wr;
		logic flag_wr;
		logic flag_n;
		logic flag_z;
		logic indexed;
	} state_t;

endpackage

// [hw/operand_addr_if.sv]
// operand address request and answer between decoder and address former
`timescale 1ns/1ps
interface operand_addr_if;
	logic [7:0] file;
	logic access_sel;
	logic [3:0] bank;
	logic ext_on;
	logic [11:0] index_base;
	logic [11:0] addr;
	logic indexed;

	modport req (output file, output access_sel, output bank, output ext_on,
		output index_base, input addr, input indexed);
	modport former (input file, input access_sel, input bank, input ext_on,
		input index_base, output addr, output indexed);
endinterface

// [hw/operand_address.sv]
// forms the data memory address of a byte operand
`timescale 1ns/1ps
`include "compare_skip_map.svh"
module operand_address (
	operand_addr_if.former bus
);
	import compare_skip_pkg::*;

	logic low_half;

	// low file addresses may be indexed off the base pointer
	assign low_half = (bus.file <= `CSU_INDEX_LIMIT);

	// indexed literal offset wins over the access bank when enabled
	always_comb begin
		bus.indexed = 1'b0;
		if (bus.access_sel) begin
			bus.addr = {bus.bank, bus.file};
		end else if (bus.ext_on && low_half) begin
			bus.addr = bus.index_base + {4'h0, bus.file};
			bus.indexed = 1'b1;
		end else if (low_half) begin
			bus.addr = {`CSU_ACCESS_LOW_PAGE, bus.file};
		end else begin
			bus.addr = {`CSU_ACCESS_HIGH_PAGE, bus.file};
		end
	end
endmodule // operand_address

// [hw/compare_skip_unit.sv]
// execution of the compare-and-skip and complement byte instructions
`timescale 1ns/1ps
`include "compare_skip_map.svh"
// How it works
// - equal compare skips, flags untouched
// - equal opcode 0110 001, bank bit, file
// - greater opcode 0110 010 skips on greater
// - less opcode 0110 000 skips on less
// - taken skip flushes, adds one no-op cycle
// - two-word next instruction adds two no-ops
// - bank bit zero selects access bank
// - bank bit one uses bank select register
// - extended set, bank bit zero, low file: indexed offset
// - complement inverts, writes in Q4, sets N,Z
module compare_skip_unit (
	input wire logic i_mclk,
	input wire logic i_reset,
	input wire logic i_instr_valid,
	input wire logic [15:0] i_instr,
	input wire logic i_next_two_word,
	input wire logic [7:0] i_working_register,
	input wire logic [3:0] i_bank_select_register,
	input wire logic i_ext_enable,
	input wire logic [11:0] i_index_base,
	input wire logic [7:0] i_mem_rdata,
	output compare_skip_pkg::phase_t o_phase,
	output logic o_flush,
	output logic o_nop_cycle,
	output logic [11:0] o_mem_addr,
	output logic o_mem_rd,
	output logic o_mem_wr,
	output logic [7:0] o_mem_wdata,
	output logic o_working_wr,
	output logic [7:0] o_working_data,
	output logic o_flag_wr,
	output logic o_flag_n,
	output logic o_flag_z,
	output logic o_indexed
);
	import compare_skip_pkg::*;

	// registered state and the decode helpers around it
	state_t state;
	state_t next_state;
	op_t decoded_op;
	logic skip_taken;
	logic [1:0] nop_after;
	logic take_now;
	logic is_complement;
	logic op_active;
	logic last_nop;
	logic [7:0] complement_value;

	// address former sits behind its own interface so it stays reusable
	operand_addr_if addr_bus ();

	operand_address u_operand_address (
		.bus(addr_bus.former)
	);

	// the address is formed straight from the word on offer in Q1
	assign addr_bus.file = i_instr[`CSU_FILE_HI:`CSU_FILE_LO];
	assign addr_bus.access_sel = i_instr[`CSU_BANK_BIT];
	assign addr_bus.bank = i_bank_select_register;
	assign addr_bus.ext_on = i_ext_enable;
	assign addr_bus.index_base = i_index_base;

	// opcode decode; anything else belongs to the rest of the core
	always_comb begin
		decoded_op = OP_NONE;
		case (i_instr[`CSU_OP7_HI:`CSU_OP7_LO])
			`CSU_OP_SKIP_EQUAL: decoded_op = OP_SKIP_EQUAL;
			`CSU_OP_SKIP_GREATER: decoded_op = OP_SKIP_GREATER;
			`CSU_OP_SKIP_LESS: decoded_op = OP_SKIP_LESS;
			default: decoded_op = OP_NONE;
		endcase
		if (is_complement) begin
			decoded_op = OP_COMPLEMENT;
		end
	end

	// the six-bit complement prefix cannot overlap the compare prefixes
	assign is_complement = (i_instr[`CSU_OP7_HI:`CSU_OP6_LO] == `CSU_OP_COMPLEMENT);

	// an instruction is only accepted in Q1 of a cycle that is not a no-op
	assign take_now = (state.phase == PH_DECODE) && !state.nop_cycle && i_instr_valid;

	// operand and working register are only latched for our own ops
	assign op_active = (state.op != OP_NONE);

	// unsigned compare of the operand byte against the working register
	always_comb begin
		case (state.op)
			OP_SKIP_EQUAL: skip_taken = (state.operand == state.working);
			OP_SKIP_GREATER: skip_taken = (state.operand > state.working);
			OP_SKIP_LESS: skip_taken = (state.operand < state.working);
			default: skip_taken = 1'b0;
		endcase
	end

	// complement result and flags come from the latched operand
	assign complement_value = ~state.operand;

	// a two-word successor needs its second word discarded too
	always_comb begin
		if (i_next_two_word) begin
			nop_after = `CSU_NOP_TWO_WORD;
		end else begin
			nop_after = `CSU_NOP_ONE_WORD;
		end
	end

	// the last no-op cycle ends when one step is left
	assign last_nop = (state.nop_left == `CSU_NOP_STEP);

	// one step of the quarter phase sequencer
	always_comb begin
		next_state = state;
		next_state.flush = 1'b0;
		next_state.mem_wr = 1'b0;
		next_state.working_wr = 1'b0;
		next_state.flag_wr = 1'b0;
		case (state.phase)
			PH_DECODE: begin
				next_state.phase = PH_READ;
				// no-op cycles take nothing from the fetch stage
				if (take_now) begin
					next_state.op = decoded_op;
				end else begin
					next_state.op = OP_NONE;
				end
				// idle cycles keep the last address so it holds until overwritten
				if (next_state.op != OP_NONE) begin
					next_state.dest_working = i_instr[`CSU_DEST_BIT];
					next_state.mem_addr = addr_bus.addr;
					next_state.indexed = addr_bus.indexed;
				end
				next_state.mem_rd = (next_state.op != OP_NONE);
			end
			PH_READ: begin
				// Q2: read strobe ends as the byte is taken
				next_state.phase = PH_PROCESS;
				next_state.mem_rd = 1'b0;
				if (op_active) begin
					next_state.operand = i_mem_rdata;
					next_state.working = i_working_register;
				end
			end
			PH_PROCESS: begin
				// Q3: compares drive no write and no flag strobe
				next_state.phase = PH_WRITE;
				if (state.op == OP_COMPLEMENT) begin
					next_state.result = complement_value;
					next_state.mem_wr = !state.dest_working;
					next_state.working_wr = state.dest_working;
					next_state.flag_wr = 1'b1;
					next_state.flag_n = complement_value[7];
					next_state.flag_z = (complement_value == `CSU_BYTE_ZERO);
				end
				next_state.flush = skip_taken;
			end
			PH_WRITE: begin
				next_state.phase = PH_DECODE;
				next_state.op = OP_NONE;
				// a taken skip turns the following cycles into no-ops
				if (state.flush) begin
					next_state.nop_left = nop_after;
					next_state.nop_cycle = 1'b1;
				end else if (state.nop_cycle) begin
					next_state.nop_left = state.nop_left - `CSU_NOP_STEP;
					next_state.nop_cycle = !last_nop;
				end
			end
			default: begin
				next_state.phase = PH_DECODE;
			end
		endcase
	end

	// synchronous reset puts the sequencer at Q1 with nothing pending
	always_ff @(posedge i_mclk) begin
		if (i_reset) begin
			state.phase <= PH_DECODE;
			state.op <= OP_NONE;
			state.dest_working <= 1'b0;
			state.operand <= `CSU_BYTE_ZERO;
			state.working <= `CSU_BYTE_ZERO;
			state.result <= `CSU_BYTE_ZERO;
			state.nop_left <= `CSU_NOP_NONE;
			state.nop_cycle <= 1'b0;
			state.flush <= 1'b0;
			state.mem_addr <= `CSU_ADDR_ZERO;
			state.mem_rd <= 1'b0;
			state.mem_wr <= 1'b0;
			state.working_wr <= 1'b0;
			state.flag_wr <= 1'b0;
			state.flag_n <= 1'b0;
			state.flag_z <= 1'b0;
			state.indexed <= 1'b0;
		end else begin
			state <= next_state;
		end
	end

	// sequencer view: quarter phase, flush and no-op marker
	assign o_phase = state.phase;
	assign o_flush = state.flush;
	assign o_nop_cycle = state.nop_cycle;

	// data memory side; the address holds between operand reads
	assign o_mem_addr = state.mem_addr;
	assign o_mem_rd = state.mem_rd;
	assign o_mem_wr = state.mem_wr;
	assign o_mem_wdata = state.result;

	// working register side shares the complement result
	assign o_working_wr = state.working_wr;
	assign o_working_data = state.result;

	// status flags hold until the next flag write, the addressing mode until the next operand address
	assign o_flag_wr = state.flag_wr;
	assign o_flag_n = state.flag_n;
	assign o_flag_z = state.flag_z;
	assign o_indexed = state.indexed;
endmodule // compare_skip_unit

// [hw/README_unused.sv]
// intentionally empty file holding no design content
`timescale 1ns/1ps

// [sim/compare_skip_unit_monitor.sv]
// concurrent checks on the ports of the compare and skip unit
`timescale 1ns/1ps
module compare_skip_unit_monitor
	import compare_skip_pkg::*;
(
	input wire logic i_mclk,
	input wire logic i_reset,
	input wire logic i_instr_valid,
	input wire logic [15:0] i_instr,
	input wire logic i_next_two_word,
	input wire logic [3:0] i_bank_select_register,
	input wire compare_skip_pkg::phase_t o_phase,
	input wire logic o_flush,
	input wire logic o_nop_cycle,
	input wire logic [11:0] o_mem_addr,
	input wire logic o_mem_rd,
	input wire logic o_mem_wr,
	input wire logic o_working_wr,
	input wire logic o_flag_wr
);
	default clocking @(posedge i_mclk); endclocking
	default disable iff (i_reset);
	// a compare or complement taken at the decode quarter
	sequence take_cmp;
		o_phase == PH_DECODE && !o_nop_cycle && i_instr_valid &&
			i_instr[15:11] == 5'h0c && i_instr[10:9] != 2'b11;
	endsequence
	sequence take_com;
		o_phase == PH_DECODE && !o_nop_cycle && i_instr_valid && i_instr[15:10] == 6'h07;
	endsequence
	chk_read_after_take: assert property (take_cmp |=> o_mem_rd ##2 o_phase == PH_WRITE)
		else $error("operand read missing after compare");
	chk_cmp_no_write: assert property (take_cmp |=> (!o_mem_wr && !o_working_wr && !o_flag_wr)[*3])
		else $error("compare wrote something");
	chk_flush_phase: assert property (o_flush |-> o_phase == PH_WRITE)
		else $error("flush outside fourth quarter");
	chk_one_nop: assert property (o_flush && !i_next_two_word |=> o_nop_cycle[*4] ##1 !o_nop_cycle)
		else $error("one word skip length wrong");
	chk_two_nop: assert property (o_flush && i_next_two_word |=> o_nop_cycle[*8] ##1 !o_nop_cycle)
		else $error("two word skip length wrong");
	chk_nop_quiet: assert property (o_nop_cycle |-> !(o_mem_rd || o_mem_wr || o_working_wr || o_flag_wr || o_flush))
		else $error("activity during no-op cycle");
	chk_bank_addr: assert property (take_cmp ##0 i_instr[8] |=>
		o_mem_addr == {$past(i_bank_select_register), $past(i_instr[7:0])})
		else $error("banked address wrong");
	chk_access_high: assert property (take_cmp ##0 !i_instr[8] && i_instr[7:0] > 8'h5f |=>
		o_mem_addr == {4'hf, $past(i_instr[7:0])})
		else $error("access bank address wrong");
	chk_complement_write: assert property (take_com ##0 !i_instr[9] |-> ##3 o_mem_wr && o_flag_wr)
		else $error("complement write missing in fourth quarter");
endmodule // compare_skip_unit_monitor

bind compare_skip_unit compare_skip_unit_monitor mon (
	.i_mclk(i_mclk),
	.i_reset(i_reset),
	.i_instr_valid(i_instr_valid),
	.i_instr(i_instr),
	.i_next_two_word(i_next_two_word),
	.i_bank_select_register(i_bank_select_register),
	.o_phase(o_phase),
	.o_flush(o_flush),
	.o_nop_cycle(o_nop_cycle),
	.o_mem_addr(o_mem_addr),
	.o_mem_rd(o_mem_rd),
	.o_mem_wr(o_mem_wr),
	.o_working_wr(o_working_wr),
	.o_flag_wr(o_flag_wr)
);

// [sim/data_memory_model.sv]
// data memory byte source answering the unit's operand reads
`timescale 1ns/1ps
module data_memory_model (
	input wire logic i_mem_rd,
	input wire logic [7:0] i_byte,
	output logic [7:0] o_mem_rdata
);
	// inverse outside reads so a late sample never looks right
	assign o_mem_rdata = i_mem_rd ? i_byte : ~i_byte;
endmodule // data_memory_model

// [sim/tb.sv]
// self-checking bench of the compare and skip unit
`timescale 1ns/1ps
module tb;
	import compare_skip_pkg::*;
	typedef struct {logic [15:0] ins; logic [7:0] w; logic [7:0] b; logic tw;
		logic [11:0] ea; logic [11:0] en;} row_t;
	logic i_mclk, i_reset, i_instr_valid, i_next_two_word, i_ext_enable;
	logic [15:0] i_instr;
	logic [7:0] i_working_register, i_mem_rdata, mem_byte, o_mem_wdata, o_working_data;
	logic [3:0] i_bank_select_register;
	logic [11:0] i_index_base, o_mem_addr;
	phase_t o_phase;
	logic o_flush, o_nop_cycle, o_mem_rd, o_mem_wr, o_working_wr, o_flag_wr;
	// fourth quarter strobes and data, caught while they stand
	logic [2:0] seen_wr;
	logic [7:0] seen_mdata, seen_wdata;
	logic o_flag_n, o_flag_z, o_indexed;
	int num_errors = 0;
	int checks = 0;
	// compares: expected no-op clocks are 4 per skipped word, 0 if not taken
	row_t rows[7] = '{
		'{16'h6320, 8'h5a, 8'h5a, 1'b0, 12'h320, 12'h4},
		'{16'h6320, 8'h5a, 8'h5b, 1'b0, 12'h320, 12'h0},
		'{16'h6541, 8'h7f, 8'h80, 1'b1, 12'h341, 12'h8},
		'{16'h6541, 8'h7f, 8'h7f, 1'b0, 12'h341, 12'h0},
		'{16'h61ff, 8'h01, 8'h00, 1'b0, 12'h3ff, 12'h4},
		'{16'h61ff, 8'hff, 8'hff, 1'b0, 12'h3ff, 12'h0},
		'{16'h61ff, 8'h00, 8'hff, 1'b1, 12'h3ff, 12'h0}};

	compare_skip_unit dut (
		.i_mclk(i_mclk),
		.i_reset(i_reset),
		.i_instr_valid(i_instr_valid),
		.i_instr(i_instr),
		.i_next_two_word(i_next_two_word),
		.i_working_register(i_working_register),
		.i_bank_select_register(i_bank_select_register),
		.i_ext_enable(i_ext_enable),
		.i_index_base(i_index_base),
		.i_mem_rdata(i_mem_rdata),
		.o_phase(o_phase),
		.o_flush(o_flush),
		.o_nop_cycle(o_nop_cycle),
		.o_mem_addr(o_mem_addr),
		.o_mem_rd(o_mem_rd),
		.o_mem_wr(o_mem_wr),
		.o_mem_wdata(o_mem_wdata),
		.o_working_wr(o_working_wr),
		.o_working_data(o_working_data),
		.o_flag_wr(o_flag_wr),
		.o_flag_n(o_flag_n),
		.o_flag_z(o_flag_z),
		.o_indexed(o_indexed)
	);
	data_memory_model mem (.i_mem_rd(o_mem_rd), .i_byte(mem_byte), .o_mem_rdata(i_mem_rdata));

	// 50 ns period
	initial begin
		i_mclk = 1'b0;
		forever #25 i_mclk = ~i_mclk;
	end

	task automatic chk(input logic [11:0] g, input logic [11:0] e);
		checks++;
		if (g !== e) begin
			num_errors++;
			$display("mismatch t=%0t got %h exp %h", $time, g, e);
		end
	endtask

	task automatic give_verdict();
		$display("errors %0d checks %0d", num_errors, checks);
		if (num_errors == 0 && checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	// offer one instruction at a free decode quarter, then count no-op clocks
	task automatic run(input row_t r);
		logic [11:0] n;
		n = 12'h0;
		while (o_phase !== PH_DECODE || o_nop_cycle !== 1'b0)
			@(negedge i_mclk);
		i_instr = r.ins;
		i_working_register = r.w;
		mem_byte = r.b;
		i_next_two_word = r.tw;
		i_instr_valid = 1'b1;
		@(negedge i_mclk);
		i_instr_valid = 1'b0;
		chk(o_mem_addr, r.ea);
		chk(o_mem_rd, 1'b1);
		repeat (2) @(negedge i_mclk);
		chk(o_flush, r.en != 12'h0);
		seen_wr = {o_mem_wr, o_working_wr, o_flag_wr};
		seen_mdata = o_mem_wdata;
		seen_wdata = o_working_data;
		repeat (12) begin
			@(negedge i_mclk);
			n = n + o_nop_cycle;
		end
		chk(n, r.en);
	endtask

	// hang guard, far beyond the roughly 220 clocks the run needs
	initial begin
		#200000;
		num_errors++;
		give_verdict();
	end

	initial begin
		i_reset = 1'b1;
		i_instr_valid = 1'b0;
		i_instr = 16'h0000;
		i_next_two_word = 1'b0;
		i_ext_enable = 1'b0;
		i_working_register = 8'h00;
		mem_byte = 8'h00;
		i_bank_select_register = 4'h3;
		i_index_base = 12'h000;
		repeat (16) @(negedge i_mclk);
		i_reset = 1'b0;
		chk(o_phase, PH_DECODE);
		chk({o_mem_rd, o_mem_wr, o_flush, o_nop_cycle}, 4'h0);
		foreach (rows[k]) begin
			run(rows[k]);
			chk(seen_wr, 3'h0);
		end
		run('{16'h6080, 8'h01, 8'h00, 1'b0, 12'hf80, 12'h4});
		// indexed offset only with the extended set on
		i_ext_enable = 1'b1;
		i_index_base = 12'h100;
		run('{16'h6010, 8'h01, 8'h00, 1'b0, 12'h110, 12'h4});
		chk(o_indexed, 1'b1);
		// complement write strobes stand only in the fourth quarter, results and flags hold
		run('{16'h1c33, 8'h00, 8'h13, 1'b0, 12'h133, 12'h0});
		chk(seen_wr, 3'h5);
		chk(seen_mdata, 8'hec);
		chk({o_flag_n, o_flag_z}, 2'h2);
		i_ext_enable = 1'b0;
		run('{16'h1e60, 8'h00, 8'hff, 1'b0, 12'hf60, 12'h0});
		chk(seen_wr, 3'h3);
		chk(seen_wdata, 8'h00);
		chk({o_flag_n, o_flag_z}, 2'h1);
		// valid held into a no-op cycle, then a reset in mid-skip
		while (o_phase !== PH_DECODE || o_nop_cycle !== 1'b0)
			@(negedge i_mclk);
		i_instr = 16'h6320;
		i_working_register = 8'h5a;
		mem_byte = 8'h5a;
		i_next_two_word = 1'b1;
		i_instr_valid = 1'b1;
		repeat (5) @(negedge i_mclk);
		chk({o_nop_cycle, o_mem_rd}, 2'h2);
		i_reset = 1'b1;
		i_instr_valid = 1'b0;
		repeat (2) @(negedge i_mclk);
		i_reset = 1'b0;
		chk({o_phase, o_nop_cycle, o_flush, o_mem_rd}, 5'h00);
		run(rows[0]);
		give_verdict();
	end
endmodule // tb
